// >>> rtl/dbg_pkg.sv
// Constants and types shared by the debug wire link block
package dbg_pkg;
    // ==========================================
    // Link framing
    localparam int         BREAK_BITS       = 9;
    localparam int         CHAR_BITS        = 10;
    localparam int         TX_BREAK_CHARS   = 4;
    localparam logic [7:0] AUTOBAUD_BYTE    = 8'h80;
    localparam logic [7:0] BREAKPOINT_OP    = 8'h00;
    // ==========================================
    // Counter widths and reset values
    localparam int          BIT_CNT_W       = 16;
    localparam int          BIT_IDX_W       = 4;
    localparam logic [15:0] BIT_TIME_RST    = 16'h0000;
    localparam int          FIFO_WIDTH      = 8;
    localparam int          FIFO_DEPTH      = 32;
    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam int          CTRL_BRK_EN_BIT = 7;
    // Least line-low run taken as the autobaud low span (start bit plus seven zeros)
    localparam logic [15:0] MIN_BIT_TIME    = 16'h0004;

    typedef enum logic [2:0] {
        ST_TRAIN  = 3'b000,
        ST_IDLE   = 3'b001,
        ST_RX     = 3'b011,
        ST_TX     = 3'b010,
        ST_SBRK   = 3'b110,
        ST_HBRK   = 3'b111
    } link_state_e;
endpackage

// >>> rtl/dbg_fifo_if.sv
// Valid/ready stream between the link and its receive FIFO
interface dbg_fifo_if;
    import dbg_pkg::*;
    logic [FIFO_WIDTH-1:0] data;
    logic                  valid;
    logic                  ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface

// >>> rtl/dbg_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
module dbg_fifo
    import dbg_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    // Fill side
    dbg_fifo_if.dst               wr,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_s;

    fifo_s st;
    fifo_s next_st;
    logic  push;
    logic  pop;

    assign wr.ready  = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rp];
    assign push      = wr.valid && wr.ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st.wp  = '0;
            next_st.rp  = '0;
            next_st.cnt = '0;
        end else begin
            if (push) begin
                next_st.mem[st.wp] = wr.data;
                next_st.wp         = st.wp + 1'b1;
            end
            if (pop) begin
                next_st.rp = st.rp + 1'b1;
            end
            next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// >>> rtl/debug_serial_error_breakpoint.sv
// Debug wire link error handling and breakpoint control
// Summary of operation
// - Nine bit times low resets autobaud
// - Low stop bit flags framing error
// - Host driving during transmit is collision
// - Any link error aborts current command
// - Error answered with four-character break
// - Error clears autobaud detector and generator
// - Open-drain pin lets host break in idle, receive or transmit
// - Host break keeps debug control register
// - Halted state survives a serial break
// - Controller held in reset during break
// - Opcode 00H signals the debug controller
// - Enabled breakpoint halts and idles processor
// - Disabled breakpoint ignored, acts as no-op
module debug_serial_error_breakpoint
    import dbg_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Debug wire pin, open drain
    input  wire logic       debug_wire_pin_in,
    output logic            debug_wire_pin_out,
    output logic            debug_wire_pin_oe,
    // Processor side
    input  wire logic       decode_valid,
    input  wire logic [7:0] decode_opcode,
    output logic            cpu_idle,
    output logic            debug_halted,
    // Debug control register access from command logic
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       resume,
    output logic [7:0]      debug_control_register,
    // Transmit character from command logic
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Received bytes toward command logic
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // Error and status
    output logic            cmd_abort,
    output logic            framing_error,
    output logic            collision_error,
    output logic            break_seen,
    output logic            baud_locked
);
    // ==========================================
    // State
    typedef struct packed {
        logic [1:0]           sync;
        link_state_e          fsm;
        logic [BIT_CNT_W-1:0] bit_time;
        logic [BIT_CNT_W-1:0] tick;
        logic [BIT_CNT_W-1:0] low_run;
        logic [BIT_IDX_W-1:0] low_bits;
        logic [BIT_IDX_W-1:0] bit_idx;
        logic [5:0]           brk_bits;
        logic [9:0]           shift;
        logic                 line_prev;
        logic [7:0]           ctrl;
        logic                 halted;
        logic                 abort;
        logic                 ferr;
        logic                 coll;
        logic                 breakpoint_opcode;
        logic                 pin_out;
        logic [7:0]           wr_data;
        logic                 wr_valid;
        logic                 tx_rdy;
        logic                 skip_run;
        logic                 locked;
    } link_s;

    link_s       st;
    link_s       next_st;
    logic        line;
    logic        fifo_flush;
    dbg_fifo_if  rxq ();

    assign line = st.sync[1];

    dbg_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .flush     (fifo_flush),
        .wr        (rxq.dst),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign rxq.data   = st.wr_data;
    assign rxq.valid  = st.wr_valid;
    assign fifo_flush = st.abort;

    // ==========================================
    // Next state
    always_comb begin
        logic error;
        logic brk_done;
        error    = 1'b0;
        brk_done = 1'b0;
        next_st  = st;
        next_st.sync      = {st.sync[0], debug_wire_pin_in};
        next_st.line_prev = line;
        next_st.abort     = 1'b0;
        next_st.ferr      = 1'b0;
        next_st.coll      = 1'b0;
        next_st.breakpoint_opcode       = 1'b0;
        next_st.tx_rdy    = 1'b0;
        // One-cycle offer: a full queue drops the byte
        next_st.wr_valid  = 1'b0;

        // Continuous low-line measurement in bit times, counted whenever bit_time is nonzero
        if (line) begin
            next_st.low_run  = '0;
            next_st.low_bits = '0;
        end else if (st.bit_time != '0) begin
            if (st.low_run == st.bit_time - 1'b1) begin
                next_st.low_run = '0;
                if (st.low_bits != 4'(BREAK_BITS)) begin
                    next_st.low_bits = st.low_bits + 1'b1;
                end
            end else begin
                next_st.low_run = st.low_run + 1'b1;
            end
        end

        // Breakpoint: enabled opcode 00H halts, otherwise no-op
        if (decode_valid && decode_opcode == BREAKPOINT_OP) begin
            if (st.ctrl[CTRL_BRK_EN_BIT]) begin
                next_st.halted = 1'b1;
            end
        end
        if (resume) begin
            next_st.halted = 1'b0;
        end
        if (ctrl_wr) begin
            next_st.ctrl = ctrl_wdata;
        end

        case (st.fsm)
            ST_TRAIN: begin
                // Start bit plus seven zeros of 80H: low run spans eight bit times
                if (!line) begin
                    next_st.tick = (st.tick == '1) ? st.tick : st.tick + 1'b1;
                end else if (st.tick != '0) begin
                    // First low run after reset is the host's connect break
                    if (st.skip_run) begin
                        next_st.skip_run = 1'b0;
                    end else if (st.tick >= MIN_BIT_TIME) begin
                        next_st.bit_time = st.tick >> 3;
                        next_st.fsm      = ST_IDLE;
                    end
                    next_st.tick = '0;
                end
            end
            ST_IDLE: begin
                if (st.line_prev && !line) begin
                    next_st.fsm     = ST_RX;
                    next_st.tick    = st.bit_time >> 1;
                    next_st.bit_idx = '0;
                end else if (tx_valid) begin
                    next_st.tx_rdy  = 1'b1;
                    next_st.shift   = {1'b1, tx_data, 1'b0};
                    next_st.fsm     = ST_TX;
                    next_st.tick    = '0;
                    next_st.bit_idx = '0;
                end
            end
            ST_RX: begin
                if (st.tick == st.bit_time - 1'b1) begin
                    next_st.tick    = '0;
                    next_st.shift   = {line, st.shift[9:1]};
                    next_st.bit_idx = st.bit_idx + 1'b1;
                    if (st.bit_idx == 4'(CHAR_BITS - 1)) begin
                        next_st.fsm = ST_IDLE;
                        if (!line) begin
                            next_st.ferr = 1'b1;
                            error        = 1'b1;
                        end else begin
                            // Full queue drops the byte rather than stall the wire
                            next_st.wr_data  = st.shift[9:2];
                            next_st.wr_valid = 1'b1;
                        end
                    end
                end else begin
                    next_st.tick = st.tick + 1'b1;
                end
            end
            ST_TX: begin
                next_st.pin_out = st.shift[0];
                // Check mid-bit that a released line really reads high
                if (st.tick == (st.bit_time >> 1) && st.pin_out && !line) begin
                    next_st.coll = 1'b1;
                    error        = 1'b1;
                end
                if (st.tick == st.bit_time - 1'b1) begin
                    next_st.tick    = '0;
                    next_st.shift   = {1'b1, st.shift[9:1]};
                    next_st.bit_idx = st.bit_idx + 1'b1;
                    next_st.pin_out = st.shift[1];
                    if (st.bit_idx == 4'(CHAR_BITS - 1)) begin
                        next_st.fsm     = ST_IDLE;
                        next_st.pin_out = 1'b1;
                    end
                end else begin
                    next_st.tick = st.tick + 1'b1;
                end
            end
            ST_SBRK: begin
                next_st.pin_out = 1'b0;
                brk_done        = 1'b0;
                if (st.tick == st.bit_time - 1'b1) begin
                    next_st.tick     = '0;
                    next_st.brk_bits = st.brk_bits + 1'b1;
                    brk_done = (st.brk_bits == 6'(TX_BREAK_CHARS * CHAR_BITS - 1));
                end else begin
                    next_st.tick = st.tick + 1'b1;
                end
                if (brk_done) begin
                    next_st.pin_out  = 1'b1;
                    next_st.fsm      = ST_HBRK;
                    next_st.bit_time = BIT_TIME_RST;
                    next_st.tick     = '0;
                end
            end
            ST_HBRK: begin
                // Held in reset until the wire floats high again
                if (line) begin
                    next_st.fsm  = ST_TRAIN;
                    next_st.tick = '0;
                end
            end
            default: begin
                next_st.fsm = ST_TRAIN;
            end
        endcase

        // A host break may land mid-character; the open drain lets it through
        if (st.fsm != ST_SBRK && st.fsm != ST_HBRK && st.low_bits == 4'(BREAK_BITS)) begin
            next_st.breakpoint_opcode = 1'b1;
            error       = 1'b1;
        end

        if (error) begin
            next_st.abort    = 1'b1;
            next_st.wr_valid = 1'b0;
            next_st.pin_out  = 1'b0;
            next_st.fsm      = ST_SBRK;
            next_st.tick     = '0;
            next_st.brk_bits = '0;
            // Keep bit time to time the answer, then clear it
            // ctrl and halted deliberately untouched here
            next_st.halted   = next_st.halted;
            next_st.ctrl     = next_st.ctrl;
        end
        // Baud counts as lost from the first cycle of the answering break
        next_st.locked = (next_st.fsm == ST_IDLE) || (next_st.fsm == ST_RX) || (next_st.fsm == ST_TX);
    end

    // ==========================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st          <= '0;
            st.sync     <= 2'b11;
            st.line_prev<= 1'b1;
            st.pin_out  <= 1'b1;
            st.skip_run <= 1'b1;
            st.ctrl     <= CTRL_RST;
            st.fsm      <= ST_TRAIN;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs
    assign debug_wire_pin_out     = 1'b0;
    assign debug_wire_pin_oe      = !st.pin_out;
    assign cpu_idle               = st.halted;
    assign debug_halted           = st.halted;
    assign debug_control_register = st.ctrl;
    assign tx_ready               = st.tx_rdy;
    assign cmd_abort              = st.abort;
    assign framing_error          = st.ferr;
    assign collision_error        = st.coll;
    assign break_seen             = st.breakpoint_opcode;
    assign baud_locked            = st.locked;
endmodule

// >>> bench/debug_serial_error_breakpoint_props.sv
// Concurrent checks on the ports of the debug wire link block
module debug_serial_error_breakpoint_props
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_b,
    // Debug wire
    input wire logic       debug_wire_pin_in,
    input wire logic       debug_wire_pin_out,
    input wire logic       debug_wire_pin_oe,
    // Processor and control
    input wire logic       decode_valid,
    input wire logic [7:0] decode_opcode,
    input wire logic       cpu_idle,
    input wire logic       debug_halted,
    input wire logic       ctrl_wr,
    input wire logic       resume,
    input wire logic [7:0] debug_control_register,
    // Status
    input wire logic       cmd_abort,
    input wire logic       framing_error,
    input wire logic       collision_error,
    input wire logic       break_seen,
    input wire logic       baud_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic bp_on;
    logic bp_off;
    // Resume wins over a same-cycle breakpoint
    assign bp_on  = decode_valid && decode_opcode == BREAKPOINT_OP && !resume && debug_control_register[CTRL_BRK_EN_BIT];
    assign bp_off = decode_valid && decode_opcode == BREAKPOINT_OP && !debug_control_register[CTRL_BRK_EN_BIT];
    // ====================
    // Link errors
    a_err_aborts: assert property ((break_seen || framing_error || collision_error) |-> cmd_abort)
        else $error("error pulse without abort");
    a_abort_breaks: assert property (cmd_abort |=> debug_wire_pin_oe [*8])
        else $error("no break drive after abort");
    a_break_low: assert property (break_seen |-> !$past(debug_wire_pin_in, 8))
        else $error("break seen on a high wire");
    a_break_unlocks: assert property (break_seen |=> !baud_locked)
        else $error("baud kept after break");
    a_err_unlocks: assert property (framing_error || collision_error |=> !baud_locked)
        else $error("baud kept after error");
    a_open_drain: assert property (debug_wire_pin_out == 1'b0)
        else $error("pin data not low");
    // ====================
    // Control register and breakpoints
    a_ctrl_kept: assert property (!ctrl_wr |=> $stable(debug_control_register))
        else $error("control register changed");
    a_bp_halts: assert property (bp_on |=> debug_halted && cpu_idle)
        else $error("breakpoint did not halt");
    a_bp_ignored: assert property (bp_off && !debug_halted |=> !debug_halted && !cpu_idle)
        else $error("disabled breakpoint halted");
    a_halt_holds: assert property (debug_halted && !resume |=> debug_halted)
        else $error("halted state lost");
endmodule

bind debug_serial_error_breakpoint debug_serial_error_breakpoint_props u_props (
    .core_clk, .rst_b, .debug_wire_pin_in, .debug_wire_pin_out, .debug_wire_pin_oe, .decode_valid,
    .decode_opcode, .cpu_idle, .debug_halted, .ctrl_wr, .resume, .debug_control_register,
    .cmd_abort, .framing_error, .collision_error, .break_seen, .baud_locked
);

// >>> bench/dbg_host_model.sv
// Host adapter model on the open-drain debug wire
module dbg_host_model
    import dbg_pkg::*;
#(
    parameter int BIT = 8
) (
    // Clock
    input  wire logic core_clk,
    // Wire level in, pull-down request out
    input  wire logic wire_lvl,
    output logic      host_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial host_low = 1'b0;
    // ====================
    // Framing, 8N1 LSB first
    task automatic send_char(input logic [7:0] b, input logic stop);
        logic [9:0] f;
        f = {stop, b, 1'b0};
        for (int i = 0; i < CHAR_BITS; i++) begin
            @(posedge core_clk);
            host_low <= !f[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        host_low <= 1'b0;
    endtask
    // Open drain lets the host break at any time
    task automatic hold_low(input int n);
        @(posedge core_clk);
        host_low <= 1'b1;
        repeat (n) @(posedge core_clk);
        host_low <= 1'b0;
    endtask
    // Training only makes sense once the device's own break has ended
    task automatic retrain();
        for (int k = 0; k < 4000 && wire_lvl !== 1'b1; k++) @(posedge core_clk);
        // Let the device's synchroniser see the high wire first
        repeat (4) @(posedge core_clk);
        send_char(AUTOBAUD_BYTE, 1'b1);
    endtask
endmodule

// >>> bench/debug_serial_error_breakpoint_test.sv
// Self-checking bench for the debug wire link block
module debug_serial_error_breakpoint_test
    import dbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 8;
    logic        core_clk, host_low, debug_wire_pin_in, debug_wire_pin_out, debug_wire_pin_oe;
    logic        cpu_idle, debug_halted, tx_ready, rx_valid, cmd_abort, framing_error;
    logic        collision_error, break_seen, baud_locked;
    logic        rst_b = 1'b0, decode_valid = 1'b0, ctrl_wr = 1'b0, resume = 1'b0;
    logic        tx_valid = 1'b0, rx_ready = 1'b1;
    logic [7:0]  decode_opcode = 8'h00, ctrl_wdata = 8'h00, tx_data = 8'h00;
    logic [7:0]  debug_control_register, rx_data;
    logic [7:0]  got[$];
    int          failures, n_compared, n_fe, n_col, n_brk, n_abort, n_txr, n_oe, m;
    // Control value, opcode, expected halt
    logic [16:0] rows[5] = '{{8'h80, 8'h00, 1'b1}, {8'h00, 8'h00, 1'b0}, {8'h80, 8'h01, 1'b0},
                             {8'h7f, 8'h00, 1'b0}, {8'hff, 8'h00, 1'b1}};

    debug_serial_error_breakpoint u_dut (
        .core_clk, .rst_b, .debug_wire_pin_in, .debug_wire_pin_out, .debug_wire_pin_oe, .decode_valid,
        .decode_opcode, .cpu_idle, .debug_halted, .ctrl_wr, .ctrl_wdata, .resume, .debug_control_register,
        .tx_valid, .tx_data, .tx_ready, .rx_data, .rx_valid, .rx_ready, .cmd_abort, .framing_error,
        .collision_error, .break_seen, .baud_locked
    );
    dbg_host_model #(.BIT(BIT)) u_host (.core_clk, .wire_lvl(debug_wire_pin_in), .host_low);
    // Pull-up wire: either party pulls it low
    assign debug_wire_pin_in = !(host_low || debug_wire_pin_oe);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ====================
    // Pulse counters, so one-cycle pulses are never missed
    always @(posedge core_clk) begin
        if (framing_error === 1'b1) n_fe <= n_fe + 1;
        if (collision_error === 1'b1) n_col <= n_col + 1;
        if (break_seen === 1'b1) n_brk <= n_brk + 1;
        if (cmd_abort === 1'b1) n_abort <= n_abort + 1;
        if (tx_ready === 1'b1) n_txr <= n_txr + 1;
        if (debug_wire_pin_oe === 1'b1) n_oe <= n_oe + 1;
        if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
    end
    // ====================
    // Checking and closing
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            failures++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Waits out the device's answering break, then checks and retrains
    task automatic after_error(input int fe, col, breakpoint_opcode, ab);
        int k;
        repeat (2 * BIT) @(negedge core_clk);
        for (k = 0; k < 3000 && !(debug_wire_pin_in && !debug_wire_pin_oe); k++) @(negedge core_clk);
        if (k == 3000) begin
            failures++;
            $display("FAIL %0t wire stuck low", $time);
            complete_run();
        end
        check(n_fe == fe && n_col == col && n_brk == breakpoint_opcode, "error kind");
        check(n_abort == ab, "abort count");
        check(baud_locked === 1'b0, "baud kept");
        u_host.retrain();
        @(negedge core_clk);
        check(baud_locked === 1'b1, "no relock");
    endtask
    // ====================
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (2 * BIT) @(posedge core_clk);
        u_host.hold_low(12 * BIT);
        repeat (2 * BIT) @(posedge core_clk);
        u_host.retrain();
        @(negedge core_clk);
        check(baud_locked === 1'b1, "no lock");
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            ctrl_wr    <= 1'b1;
            ctrl_wdata <= rows[i][16:9];
            resume     <= 1'b1;
            @(posedge core_clk);
            ctrl_wr       <= 1'b0;
            resume        <= 1'b0;
            decode_valid  <= 1'b1;
            decode_opcode <= rows[i][8:1];
            @(posedge core_clk);
            decode_valid <= 1'b0;
            @(negedge core_clk);
            check(debug_halted === rows[i][0] && cpu_idle === rows[i][0], "halt state");
            check(debug_control_register === rows[i][16:9], "ctrl value");
        end
        m = n_oe;
        u_host.hold_low(12 * BIT);
        after_error(0, 0, 1, 1);
        check(n_oe - m == TX_BREAK_CHARS * CHAR_BITS * BIT, "break length");
        check(debug_halted === 1'b1 && debug_control_register === 8'hff, "state lost");
        u_host.send_char(8'h3c, 1'b0);
        after_error(1, 0, 1, 2);
        @(posedge core_clk);
        tx_valid <= 1'b1;
        tx_data  <= 8'hff;
        m = n_txr;
        for (int k = 0; k < 500 && n_txr == m; k++) @(negedge core_clk);
        check(n_txr == m + 1, "tx not taken");
        @(posedge core_clk);
        tx_valid <= 1'b0;
        repeat (2 * BIT) @(posedge core_clk);
        u_host.hold_low(2 * BIT);
        after_error(1, 1, 1, 3);
        @(posedge core_clk);
        rx_ready <= 1'b0;
        // A zero byte is nine low bits, a break; send 1 upward
        for (int i = 0; i <= FIFO_DEPTH; i++) u_host.send_char(8'(i + 1), 1'b1);
        got.delete();
        @(posedge core_clk);
        rx_ready <= 1'b1;
        repeat (3 * FIFO_DEPTH) @(negedge core_clk);
        check(got.size() == FIFO_DEPTH, "fifo count");
        for (int i = 0; i < FIFO_DEPTH; i++) check(got[i] === 8'(i + 1), "fifo data");
        complete_run();
    end
endmodule
